// File: rtl/prm_pkg.sv
// constants, register map and state codes of the power reduction controller
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package prm_pkg;
    // register byte addresses
    localparam logic [7:0] PRM_CTRL_ADDR = 8'h00;
    localparam logic [7:0] PRM_WAKE_ADDR = 8'h04;
    localparam logic [7:0] PRM_STAT_ADDR = 8'h08;
    // power_control_register fields
    localparam int PRM_IDLE_BIT = 0;
    localparam int PRM_PDOWN_BIT = 1;
    localparam int PRM_LOCK_BIT = 2;
    localparam int PRM_FLAG0_BIT = 3;
    localparam int PRM_FLAG1_BIT = 4;
    // wake configuration fields
    localparam int PRM_EXT0_EN_BIT = 0;
    localparam int PRM_EXT1_EN_BIT = 1;
    localparam int PRM_KEY_EN_LSB = 2;
    localparam int PRM_KEY_POL_BIT = 6;
    // status fields
    localparam int PRM_ST_CPU_BIT = 3;
    localparam int PRM_ST_PER_BIT = 4;
    localparam int PRM_ST_OSC_BIT = 5;
    localparam int PRM_ST_RAMB_BIT = 6;
    // reset values
    localparam logic [4:0] PRM_CTRL_RST = 5'h00;
    localparam logic [6:0] PRM_WAKE_RST = 7'h00;
    // oscillator settle count after a key wake, in clocks
    localparam int PRM_KEY_WAKE_CLKS = 1024;
    localparam int PRM_KEY_CNT_W = 11;
    typedef enum logic [2:0] {
        PRM_RUN      = 3'b000,
        PRM_IDLE     = 3'b001,
        PRM_PDOWN    = 3'b010,
        PRM_WAKE_EXT = 3'b011,
        PRM_WAKE_KEY = 3'b100
    } prm_state_t;
endpackage : prm_pkg

// File: rtl/prm_sync.sv
// two flip-flop level synchroniser for asynchronous pins
`timescale 1ns/100ps
`default_nettype none
module prm_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    //--------------------------------------------------------------------------
    // synchroniser chain
    //--------------------------------------------------------------------------
    // no reset: first stage may be metastable, only stage two reads it
    always_ff @(posedge clk_i) begin
        stage1 <= d_i;
        stage2 <= stage1;
    end
    assign q_o = stage2;
endmodule : prm_sync
`default_nettype wire

// File: rtl/prm_ctrl.sv
// power reduction mode controller with APB register access
`timescale 1ns/100ps
`default_nettype none
module prm_ctrl
    import prm_pkg::*;
#(
    parameter int KEYS = 4
) (
    input wire logic CORE_CLK_I,
    input wire logic SRST_I,
    input wire logic RST_PIN_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic IRQ_PENDING_I,
    input wire logic EXT_WAKE0_I,
    input wire logic EXT_WAKE1_I,
    input wire logic [KEYS-1:0] KEY_WAKE_I,
    output logic CPU_CLK_EN_O,
    output logic PERIPH_CLK_EN_O,
    output logic OSC_RUN_O,
    output logic RAM_BLOCK_O,
    output logic SERVICE_START_O,
    output logic [4:0] CTRL_O
);
    //--------------------------------------------------------------------------
    // declarations
    //--------------------------------------------------------------------------
    logic [KEYS+1:0] pins_s;
    logic ext0_s;
    logic ext1_s;
    logic [KEYS-1:0] key_s;
    logic acc;
    logic wr_ctrl;
    logic wr_wake;
    logic [31:0] rd_word;
    logic next_pready;
    logic [31:0] next_prdata;
    logic next_pslverr;
    logic lock;
    logic flag0;
    logic flag1;
    logic [1:0] ext_en;
    logic [KEYS-1:0] key_en;
    logic key_pol;
    logic next_lock;
    logic next_flag0;
    logic next_flag1;
    logic [1:0] next_ext_en;
    logic [KEYS-1:0] next_key_en;
    logic next_key_pol;
    prm_state_t state;
    prm_state_t next_state;
    logic idle_request_bit;
    logic powerdown_request_bit;
    logic cpu_en;
    logic per_en;
    logic osc_en;
    logic ram_block;
    logic svc;
    logic [PRM_KEY_CNT_W-1:0] key_cnt;
    logic next_idle;
    logic next_pdown;
    logic next_cpu_en;
    logic next_per_en;
    logic next_osc_en;
    logic next_ram_block;
    logic next_svc;
    logic [PRM_KEY_CNT_W-1:0] next_key_cnt;
    logic ext_active;
    logic key_hit;
    logic req_idle;
    logic req_pdown;

    // true when the address selects one of our three words
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == PRM_CTRL_ADDR) || (a == PRM_WAKE_ADDR) ||
                 (a == PRM_STAT_ADDR);
    endfunction : mapped

    //--------------------------------------------------------------------------
    // pin synchronisers
    //--------------------------------------------------------------------------
    // wake pins come from outside the clock domain
    prm_sync #(
        .WIDTH(KEYS + 2)
    ) u_sync (
        .clk_i(CORE_CLK_I),
        .d_i({KEY_WAKE_I, EXT_WAKE1_I, EXT_WAKE0_I}),
        .q_o(pins_s)
    );
    assign ext0_s = pins_s[0];
    assign ext1_s = pins_s[1];
    assign key_s = pins_s[KEYS+1:2];

    //--------------------------------------------------------------------------
    // apb slave
    //--------------------------------------------------------------------------
    // one wait state: the access completes on the second access-phase edge
    assign acc = PSEL_I & PENABLE_I & PREADY_O;
    assign wr_ctrl = acc & PWRITE_I & (PADDR_I == PRM_CTRL_ADDR);
    assign wr_wake = acc & PWRITE_I & (PADDR_I == PRM_WAKE_ADDR);

    // read mux, reserved bits read as zero
    always_comb begin
        rd_word = 32'h0000_0000;
        if (PADDR_I == PRM_CTRL_ADDR) begin
            rd_word[PRM_IDLE_BIT] = idle_request_bit;
            rd_word[PRM_PDOWN_BIT] = powerdown_request_bit;
            rd_word[PRM_LOCK_BIT] = lock;
            rd_word[PRM_FLAG0_BIT] = flag0;
            rd_word[PRM_FLAG1_BIT] = flag1;
        end else if (PADDR_I == PRM_WAKE_ADDR) begin
            rd_word[PRM_EXT1_EN_BIT:PRM_EXT0_EN_BIT] = ext_en;
            rd_word[PRM_KEY_EN_LSB +: KEYS] = key_en;
            rd_word[PRM_KEY_POL_BIT] = key_pol;
        end else if (PADDR_I == PRM_STAT_ADDR) begin
            rd_word[2:0] = state;
            rd_word[PRM_ST_CPU_BIT] = cpu_en;
            rd_word[PRM_ST_PER_BIT] = per_en;
            rd_word[PRM_ST_OSC_BIT] = osc_en;
            rd_word[PRM_ST_RAMB_BIT] = ram_block;
        end
    end

    always_comb begin
        next_pready = PSEL_I & PENABLE_I & ~PREADY_O;
        next_prdata = PRDATA_O;
        next_pslverr = 1'b0;
        if (next_pready) begin
            next_prdata = PWRITE_I ? 32'h0000_0000 : rd_word;
            next_pslverr = ~mapped(PADDR_I);
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            PREADY_O <= 1'b0;
            PRDATA_O <= 32'h0000_0000;
            PSLVERR_O <= 1'b0;
        end else begin
            PREADY_O <= next_pready;
            PRDATA_O <= next_prdata;
            PSLVERR_O <= next_pslverr;
        end
    end

    //--------------------------------------------------------------------------
    // software-only configuration
    //--------------------------------------------------------------------------
    always_comb begin
        next_lock = lock;
        next_flag0 = flag0;
        next_flag1 = flag1;
        next_ext_en = ext_en;
        next_key_en = key_en;
        next_key_pol = key_pol;
        if (wr_ctrl) begin
            next_lock = PWDATA_I[PRM_LOCK_BIT];
            next_flag0 = PWDATA_I[PRM_FLAG0_BIT];
            next_flag1 = PWDATA_I[PRM_FLAG1_BIT];
        end
        if (wr_wake) begin
            next_ext_en = PWDATA_I[PRM_EXT1_EN_BIT:PRM_EXT0_EN_BIT];
            next_key_en = PWDATA_I[PRM_KEY_EN_LSB +: KEYS];
            next_key_pol = PWDATA_I[PRM_KEY_POL_BIT];
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            lock <= PRM_CTRL_RST[PRM_LOCK_BIT];
            flag0 <= PRM_CTRL_RST[PRM_FLAG0_BIT];
            flag1 <= PRM_CTRL_RST[PRM_FLAG1_BIT];
            ext_en <= PRM_WAKE_RST[PRM_EXT1_EN_BIT:PRM_EXT0_EN_BIT];
            key_en <= PRM_WAKE_RST[PRM_KEY_EN_LSB +: KEYS];
            key_pol <= PRM_WAKE_RST[PRM_KEY_POL_BIT];
        end else begin
            lock <= next_lock;
            flag0 <= next_flag0;
            flag1 <= next_flag1;
            ext_en <= next_ext_en;
            key_en <= next_key_en;
            key_pol <= next_key_pol;
        end
    end

    //--------------------------------------------------------------------------
    // mode sequencer
    //--------------------------------------------------------------------------
    // lock held, or written in the same word, refuses both requests
    assign req_idle = wr_ctrl & PWDATA_I[PRM_IDLE_BIT] & ~lock &
                      ~PWDATA_I[PRM_LOCK_BIT];
    assign req_pdown = wr_ctrl & PWDATA_I[PRM_PDOWN_BIT] & ~lock &
                       ~PWDATA_I[PRM_LOCK_BIT];
    assign ext_active = (ext_en[0] & ext0_s) | (ext_en[1] & ext1_s);
    assign key_hit = |(key_en & (key_pol ? key_s : ~key_s));

    // the block itself stays on an always-on clock; only gates are steered
    always_comb begin
        next_state = state;
        next_idle = idle_request_bit;
        next_pdown = powerdown_request_bit;
        next_cpu_en = cpu_en;
        next_per_en = per_en;
        next_osc_en = osc_en;
        next_ram_block = ram_block;
        next_svc = 1'b0;
        next_key_cnt = key_cnt;
        unique case (state)
            PRM_RUN: begin
                if (req_pdown) begin
                    // deep mode wins when both bits arrive together
                    next_state = PRM_PDOWN;
                    next_pdown = 1'b1;
                    next_idle = PWDATA_I[PRM_IDLE_BIT];
                    next_cpu_en = 1'b0;
                    next_per_en = 1'b0;
                    next_osc_en = 1'b0;
                end else if (req_idle) begin
                    next_state = PRM_IDLE;
                    next_idle = 1'b1;
                    next_cpu_en = 1'b0;
                end
            end
            PRM_IDLE: begin
                if (IRQ_PENDING_I) begin
                    next_state = PRM_RUN;
                    next_idle = 1'b0;
                    next_cpu_en = 1'b1;
                    next_svc = 1'b1;
                end
            end
            PRM_PDOWN: begin
                if (ext_active) begin
                    next_state = PRM_WAKE_EXT;
                    next_pdown = 1'b0;
                    next_idle = 1'b0;
                    next_osc_en = 1'b1;
                end else if (key_hit) begin
                    next_state = PRM_WAKE_KEY;
                    next_pdown = 1'b0;
                    next_idle = 1'b0;
                    next_osc_en = 1'b1;
                    next_key_cnt = '0;
                end
            end
            PRM_WAKE_EXT: begin
                // enabled wake pin must be released before the CPU resumes
                if (!ext_active) begin
                    next_state = PRM_RUN;
                    next_cpu_en = 1'b1;
                    next_per_en = 1'b1;
                    next_svc = 1'b1;
                end
            end
            PRM_WAKE_KEY: begin
                if (key_cnt == PRM_KEY_CNT_W'(PRM_KEY_WAKE_CLKS - 1)) begin
                    next_state = PRM_RUN;
                    next_cpu_en = 1'b1;
                    next_per_en = 1'b1;
                    next_svc = 1'b1;
                end else begin
                    next_key_cnt = key_cnt + 1'b1;
                end
            end
            default: begin
                next_state = PRM_RUN;
                next_cpu_en = 1'b1;
                next_per_en = 1'b1;
                next_osc_en = 1'b1;
            end
        endcase
        if (SRST_I) begin
            // reset sequence has taken control: RAM usable again
            next_state = PRM_RUN;
            next_idle = 1'b0;
            next_pdown = 1'b0;
            next_cpu_en = 1'b1;
            next_per_en = 1'b1;
            next_osc_en = 1'b1;
            next_ram_block = 1'b0;
            next_svc = 1'b0;
            next_key_cnt = '0;
        end
    end

    // reset pin acts without the clock, which may be stopped in deep mode
    always_ff @(posedge CORE_CLK_I or posedge RST_PIN_I) begin
        if (RST_PIN_I) begin
            state <= PRM_RUN;
            idle_request_bit <= 1'b0;
            powerdown_request_bit <= 1'b0;
            cpu_en <= 1'b1;
            per_en <= 1'b1;
            osc_en <= 1'b1;
            ram_block <= 1'b1;
            svc <= 1'b0;
            key_cnt <= '0;
        end else begin
            state <= next_state;
            idle_request_bit <= next_idle;
            powerdown_request_bit <= next_pdown;
            cpu_en <= next_cpu_en;
            per_en <= next_per_en;
            osc_en <= next_osc_en;
            ram_block <= next_ram_block;
            svc <= next_svc;
            key_cnt <= next_key_cnt;
        end
    end

    //--------------------------------------------------------------------------
    // outputs
    //--------------------------------------------------------------------------
    // enables come straight from flops so the clock gates see no glitch
    assign CPU_CLK_EN_O = cpu_en;
    assign PERIPH_CLK_EN_O = per_en;
    assign OSC_RUN_O = osc_en;
    assign RAM_BLOCK_O = ram_block;
    assign SERVICE_START_O = svc;
    assign CTRL_O = {flag1, flag0, lock, powerdown_request_bit,
                     idle_request_bit};
endmodule : prm_ctrl
`default_nettype wire

// File: testbench/prm_ctrl_monitor.sv
// concurrent checks on the power reduction controller ports
`timescale 1ns/100ps
`default_nettype none
module prm_ctrl_monitor
    import prm_pkg::*;
#(
    parameter int KEYS = 4
) (
    input wire logic CORE_CLK_I,
    input wire logic SRST_I,
    input wire logic RST_PIN_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic PREADY_O,
    input wire logic IRQ_PENDING_I,
    input wire logic EXT_WAKE0_I,
    input wire logic EXT_WAKE1_I,
    input wire logic CPU_CLK_EN_O,
    input wire logic PERIPH_CLK_EN_O,
    input wire logic OSC_RUN_O,
    input wire logic RAM_BLOCK_O,
    input wire logic SERVICE_START_O,
    input wire logic [4:0] CTRL_O
);
    logic [1:0] ext_en = 2'h0;
    logic key_w = 1'b0;
    logic [11:0] cnt = 12'h000;
    logic wr_c;
    logic ext_hit;
    logic rs;
    default clocking cb @(posedge CORE_CLK_I); endclocking
    // a control write that lands in the run state with lock clear
    assign wr_c = PREADY_O && PWRITE_I && PADDR_I == PRM_CTRL_ADDR &&
        CPU_CLK_EN_O && !CTRL_O[PRM_LOCK_BIT] && !PWDATA_I[PRM_LOCK_BIT];
    assign ext_hit = (EXT_WAKE0_I && ext_en[0]) || (EXT_WAKE1_I && ext_en[1]);
    assign rs = SRST_I || RST_PIN_I;
    // external wake enables shadowed from the bus; the key wake source is
    // decided while the oscillator is still off
    always_ff @(posedge CORE_CLK_I) begin
        // the core reset clears the enables, the reset pin does not
        if (SRST_I) begin
            ext_en <= 2'h0;
        end else if (PREADY_O && PWRITE_I && PADDR_I == PRM_WAKE_ADDR) begin
            ext_en <= PWDATA_I[1:0];
        end
        if (!OSC_RUN_O) begin
            key_w <= !ext_hit;
        end
        cnt <= (OSC_RUN_O && !PERIPH_CLK_EN_O) ? cnt + 12'h001 : 12'h000;
    end
    a_idle_entry: assert property (disable iff (rs)
        wr_c && PWDATA_I[1:0] == 2'h1 |=> !CPU_CLK_EN_O && PERIPH_CLK_EN_O)
        else $error("light sleep entry wrong");
    a_deep_entry: assert property (disable iff (rs)
        wr_c && PWDATA_I[PRM_PDOWN_BIT] |=>
        !CPU_CLK_EN_O && !PERIPH_CLK_EN_O && !OSC_RUN_O)
        else $error("deep sleep entry wrong");
    a_lock_block: assert property (disable iff (rs)
        PREADY_O && PWRITE_I && PADDR_I == PRM_CTRL_ADDR && CPU_CLK_EN_O &&
        (CTRL_O[PRM_LOCK_BIT] || PWDATA_I[PRM_LOCK_BIT]) |=> CPU_CLK_EN_O[*2])
        else $error("locked request halted the core");
    a_idle_exit: assert property (disable iff (rs)
        !CPU_CLK_EN_O && PERIPH_CLK_EN_O && IRQ_PENDING_I |=>
        CPU_CLK_EN_O && SERVICE_START_O && !CTRL_O[PRM_IDLE_BIT] ##1
        !SERVICE_START_O) else $error("light sleep exit wrong");
    a_ext_wake: assert property (disable iff (rs)
        !OSC_RUN_O && ext_hit |-> ##[1:6] OSC_RUN_O && !CTRL_O[PRM_PDOWN_BIT])
        else $error("external wake not taken");
    a_ext_hold: assert property (disable iff (rs)
        OSC_RUN_O && !PERIPH_CLK_EN_O && !key_w && ext_hit |=> !CPU_CLK_EN_O)
        else $error("resumed while wake pin held");
    a_key_settle: assert property (disable iff (rs)
        $rose(CPU_CLK_EN_O) && $rose(PERIPH_CLK_EN_O) && key_w |->
        cnt > 12'h3FE && cnt < 12'h404) else $error("key settle count wrong");
    a_pin_async: assert property (disable iff (SRST_I)
        RST_PIN_I |-> CPU_CLK_EN_O && PERIPH_CLK_EN_O && OSC_RUN_O &&
        RAM_BLOCK_O) else $error("reset pin did not restore clocks");
endmodule : prm_ctrl_monitor
bind prm_ctrl prm_ctrl_monitor #(.KEYS(KEYS)) prm_ctrl_monitor_i (
    .CORE_CLK_I(CORE_CLK_I), .SRST_I(SRST_I), .RST_PIN_I(RST_PIN_I),
    .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
    .PREADY_O(PREADY_O), .IRQ_PENDING_I(IRQ_PENDING_I),
    .EXT_WAKE0_I(EXT_WAKE0_I), .EXT_WAKE1_I(EXT_WAKE1_I),
    .CPU_CLK_EN_O(CPU_CLK_EN_O), .PERIPH_CLK_EN_O(PERIPH_CLK_EN_O),
    .OSC_RUN_O(OSC_RUN_O), .RAM_BLOCK_O(RAM_BLOCK_O),
    .SERVICE_START_O(SERVICE_START_O), .CTRL_O(CTRL_O));
`default_nettype wire

// File: testbench/prm_far.sv
// behavioural interrupt source and wake pins facing the controller
`timescale 1ns/100ps
`default_nettype none
module prm_far (
    input wire logic clk_i,
    input wire logic [2:0] cmd_i,
    input wire logic pol_i,
    input wire logic service_i,
    output logic irq_o,
    output logic ext0_o,
    output logic ext1_o,
    output logic [3:0] key_o
);
    logic [2:0] src = 3'h0;
    // a source stays up until released; the interrupt drops once served
    always_ff @(posedge clk_i) begin
        if (cmd_i != 3'h0) begin
            src <= cmd_i;
        end else if (service_i && src == 3'h1) begin
            src <= 3'h0;
        end
    end
    assign irq_o = src == 3'h1;
    assign ext0_o = src == 3'h2;
    assign ext1_o = src == 3'h3;
    // idle keys rest at the level that does not wake
    assign key_o = (src == 3'h4) ? (pol_i ? 4'h4 : 4'hB) : {4{!pol_i}};
endmodule : prm_far
`default_nettype wire

// File: testbench/tb_top.sv
// self-checking bench of the power reduction controller
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import prm_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic pin = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [7:0] padr = 8'h00;
    logic [31:0] pwd = 32'h0;
    logic [31:0] prd;
    logic [31:0] lfsr = 32'h00010A28;
    logic [2:0] cmd = 3'h0;
    logic pol = 1'b1;
    logic rdy, err, irq, ext0, ext1, cpu, per, osc, ram, svc;
    logic [3:0] key;
    logic [4:0] ctrl;
    logic [2:0] mon;
    logic [6:0] wcf [4] = '{7'h01, 7'h02, 7'h7C, 7'h3C};
    logic [2:0] src [4] = '{3'h2, 3'h3, 3'h4, 3'h4};
    logic [32:0] expq [$];
    int fail_count = 0;
    int tests_run = 0;
    int n;
    always #10 clk = ~clk;
    assign mon = {svc, osc, cpu};
    prm_ctrl #(.KEYS(4)) prm_ctrl_i (
        .CORE_CLK_I(clk), .SRST_I(srst), .RST_PIN_I(pin), .PSEL_I(psel),
        .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd),
        .PRDATA_O(prd), .PREADY_O(rdy), .PSLVERR_O(err),
        .IRQ_PENDING_I(irq), .EXT_WAKE0_I(ext0), .EXT_WAKE1_I(ext1),
        .KEY_WAKE_I(key), .CPU_CLK_EN_O(cpu), .PERIPH_CLK_EN_O(per),
        .OSC_RUN_O(osc), .RAM_BLOCK_O(ram), .SERVICE_START_O(svc),
        .CTRL_O(ctrl));
    prm_far prm_far_i (.clk_i(clk), .cmd_i(cmd), .pol_i(pol),
        .service_i(svc), .irq_o(irq), .ext0_o(ext0), .ext1_o(ext1),
        .key_o(key));
    function automatic logic [31:0] nxt(input logic [31:0] v);
        nxt = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : nxt
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic end_sim;
        if (fail_count == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim
    task automatic tmo(input int k);
        if (k >= 2000) begin
            fail_count++;
            end_sim();
        end
    endtask : tmo
    // one bus transfer; reads leave their expected answer in the queue
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, input logic [32:0] e);
        int m;
        m = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        padr <= a;
        pwd <= d;
        if (!w) expq.push_back(e);
        @(posedge clk);
        pen <= 1'b1;
        // hold the request until ready is sampled high at a rising edge
        @(posedge clk);
        while (rdy !== 1'b1 && m < 2000) begin
            @(posedge clk);
            m++;
        end
        tmo(m);
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task automatic fire(input logic [2:0] c);
        @(posedge clk);
        cmd <= c;
        @(posedge clk);
        cmd <= 3'h0;
    endtask : fire
    // bounded wait for service, oscillator or core clock to rise
    task automatic wfor(input int k);
        n = 0;
        while (mon[k] !== 1'b1 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        tmo(n);
    endtask : wfor
    // read answers are taken at the rising edge that samples ready high
    always @(posedge clk) begin
        if (rdy === 1'b1 && psel && pen && !pwr && expq.size() > 0) begin
            chk({err, prd}, expq.pop_front());
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        apb(1'b0, PRM_CTRL_ADDR, 32'h0, 33'h0);
        apb(1'b0, PRM_WAKE_ADDR, 32'h0, 33'h0);
        apb(1'b1, PRM_STAT_ADDR, 32'hFFFFFFFF, 33'h0);
        apb(1'b0, PRM_STAT_ADDR, 32'h0, 33'h38);
        apb(1'b0, 8'h0C, 32'h0, 33'h100000000);
        // random flags under lock; a locked request must not halt
        lfsr = nxt(lfsr);
        apb(1'b1, PRM_CTRL_ADDR, {27'h0, lfsr[1:0], 3'h4}, 33'h0);
        apb(1'b1, PRM_CTRL_ADDR, {27'h0, lfsr[1:0], 3'h7}, 33'h0);
        apb(1'b0, PRM_CTRL_ADDR, 32'h0, {28'h0, lfsr[1:0], 3'h4});
        @(negedge clk);
        chk(cpu, 1'b1);
        apb(1'b1, PRM_CTRL_ADDR, 32'h0, 33'h0);
        // light sleep left by an interrupt after a random pause
        apb(1'b1, PRM_CTRL_ADDR, {27'h0, lfsr[1:0], 3'h1}, 33'h0);
        @(negedge clk);
        chk({cpu, per, osc}, 3'h3);
        repeat (lfsr[4:2] + 3'h2) @(posedge clk);
        fire(3'h1);
        wfor(2);
        chk({cpu, ctrl[0]}, 2'h2);
        apb(1'b0, PRM_CTRL_ADDR, 32'h0, {28'h0, lfsr[1:0], 3'h0});
        // deep sleep left by each wake source in turn
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            pol <= wcf[i][PRM_KEY_POL_BIT];
            apb(1'b1, PRM_WAKE_ADDR, {25'h0, wcf[i]}, 33'h0);
            apb(1'b1, PRM_CTRL_ADDR, {30'h0, 1'b1, i == 0}, 33'h0);
            @(negedge clk);
            chk({cpu, per, osc}, 3'h0);
            repeat (3) @(posedge clk);
            fire(src[i]);
            wfor(1);
            chk({cpu, ctrl[1]}, 2'h0);
            if (i < 2) begin
                repeat (20) @(negedge clk);
                chk(cpu, 1'b0);
                fire(3'h7);
            end
            wfor(0);
            if (i > 1) begin
                chk(n > 1019 && n < 1030, 1'b1);
                fire(3'h7);
            end
            apb(1'b0, PRM_CTRL_ADDR, 32'h0, 33'h0);
            @(negedge clk);
            chk({cpu, per}, 2'h3);
        end
        // reset pin in both modes; memory stays blocked until reset
        for (int j = 1; j < 3; j++) begin
            apb(1'b1, PRM_CTRL_ADDR, 32'(j), 33'h0);
            @(posedge clk);
            pin <= 1'b1;
            @(negedge clk);
            chk({cpu, per, osc, ram}, 4'hF);
            @(posedge clk);
            pin <= 1'b0;
            apb(1'b0, PRM_CTRL_ADDR, 32'h0, 33'h0);
            chk(ram, 1'b1);
            srst <= 1'b1;
            @(posedge clk);
            srst <= 1'b0;
            @(negedge clk);
            chk(ram, 1'b0);
        end
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
